// *** scp_pkg.sv ***
package scp_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] CLOCK_DIVIDER_CONTROL_OFS = 8'h61;
    localparam logic [7:0] RC_OSCILLATOR_TRIM_OFS = 8'h66;
    localparam logic [7:0] ASYNC_TIMER_STATUS_REGISTER_OFS = 8'hb6;

    // Field positions
    localparam int UNLOCK_BIT = 7;
    localparam int SELECT_MSB = 3;
    localparam int TRIM_RANGE_POS = 7;
    localparam int EXT_INPUT_ENABLE_POS = 6;

    // Reset values
    localparam logic [3:0] SELECT_RESET_UNPROGRAMMED = 4'h0;
    localparam logic [3:0] SELECT_RESET_PROGRAMMED = 4'h3;
    localparam logic [3:0] SELECT_MAX_VALID = 4'h8;
    localparam logic [7:0] UNLOCK_WRITE_VALUE = 8'h80;
    localparam logic [7:0] ASYNC_RESET = 8'h00;

    // Unlock window in undivided CLOCK cycles
    localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;

    // Start-up timing
    localparam int CLOCK_MHZ = 100;
    localparam logic [3:0] WAKE_CK = 4'h6;
    localparam logic [4:0] RESET_BASE_CK = 5'he;
    // Fast extra delay in tenths of a millisecond; each tenth is 100 us
    localparam int RESET_FAST_MS_X10 = 41;
    localparam int RESET_SLOW_US = 65000;
    localparam int RESET_FAST_CYC = RESET_FAST_MS_X10 * 100 * CLOCK_MHZ;
    localparam int RESET_SLOW_CYC = RESET_SLOW_US * CLOCK_MHZ;

    // Start-up time select encodings
    localparam logic [1:0] STARTUP_SEL_NO_EXTRA = 2'h0;
    localparam logic [1:0] STARTUP_SEL_FAST = 2'h1;
    localparam logic [1:0] STARTUP_SEL_SLOW = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } scp_bus_req_t;

    typedef struct packed {
        logic initial_divide_by_eight_fuse;
        logic clock_output_fuse;
        logic [1:0] startup_time_select;
        logic [7:0] factory_trim;
    } scp_fuse_t;

    typedef struct packed {
        logic io_clock_domain;
        logic converter_clock_domain;
        logic core_clock_domain;
        logic flash_clock_domain;
    } scp_domain_en_t;

    typedef enum logic [1:0] {
        ST_RESET_DELAY = 2'b00,
        ST_RUN = 2'b01,
        ST_WAKE_DELAY = 2'b10
    } scp_start_t;

endpackage : scp_pkg

// *** scp_prescaler.sv ***
// Chosen here: strobed register access.
`timescale 1ns/1ps
// How it works
// - Wake waits 6 cycles; reset waits 14 cycles plus no, fast or slow extra.
// - Async status enable bit routes an outside clock to the timer pin.
// - Clock output fuse drives the clock on the pin, also during reset.
// - Divider slows the I/O, converter, core and flash domains together.
// - Divide changes land only at period ends, so no glitch or overspeed.
// - New rate starts after the old period ends, then one new period.
// - Unlock bit sets only when all other bits are written zero.
// - Unlock clears after four cycles or on select write; select needs it.
// - Rewriting unlock during its window neither restarts nor clears it.
// - Reset loads select 0000, or 0011 when divide-by-eight fuse is set.
// - Any select value is accepted through the unlock sequence.
// - Select codes powers of two 1 to 256; higher codes also divide by 256.
// - Reset loads the factory trim value; software may overwrite it.
// - Top trim bit picks low or high oscillator range; ranges overlap.
// - Lower seven trim bits tune monotonically inside the range.
module scp_prescaler #(
    parameter int RESET_FAST_CYC = scp_pkg::RESET_FAST_CYC,
    parameter int RESET_SLOW_CYC = scp_pkg::RESET_SLOW_CYC
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire scp_pkg::scp_bus_req_t BUS_REQ,
    output logic [7:0] BUS_RDATA,
    input wire scp_pkg::scp_fuse_t FUSES,
    input wire logic WAKE_REQ,
    output scp_pkg::scp_domain_en_t DOMAIN_EN,
    output logic CLOCK_OUTPUT_PIN_O,
    output logic CLOCK_OUTPUT_PIN_OE,
    output logic [7:0] OSC_TRIM,
    output logic TRIM_RANGE_HIGH,
    output logic TIMER_OSC_EXT_SEL,
    output logic CORE_RUN
);
    import scp_pkg::*;

    typedef struct packed {
        scp_fuse_t fuse_meta;
        scp_fuse_t fuse_sync;
        logic divider_change_unlock;
        logic [2:0] unlock_left;
        logic [3:0] divider_select;
        logic [3:0] active_select;
        logic [7:0] div_count;
        logic div_phase;
        logic div_tick;
        logic [7:0] rc_oscillator_trim;
        logic [7:0] async_timer_status_register;
        logic [7:0] rdata;
        scp_start_t start_state;
        logic [22:0] start_count;
        logic core_run;
    } scp_state_t;

    scp_state_t s_q;
    scp_state_t s_d;

    // Last count of a divided period for a select code
    function automatic logic [7:0] div_limit(input logic [3:0] sel);
        logic [8:0] one_hot;
        logic [3:0] eff;
        eff = (sel > SELECT_MAX_VALID) ? SELECT_MAX_VALID : sel;
        one_hot = 9'h001 << eff;
        div_limit = 8'(one_hot - 9'h001);
    endfunction : div_limit

    // High half of the divided period; divide-by-one stays high
    function automatic logic div_high(input logic [3:0] sel, input logic [7:0] cnt);
        logic [7:0] half;
        logic [8:0] one_hot;
        logic [3:0] eff;
        eff = (sel > SELECT_MAX_VALID) ? SELECT_MAX_VALID : sel;
        one_hot = 9'h001 << eff;
        half = 8'(one_hot >> 1);
        div_high = (eff == 4'h0) ? 1'b1 : (cnt < half);
    endfunction : div_high

    function automatic logic [22:0] extra_cycles(input logic [1:0] startup_sel);
        logic [22:0] r;
        case (startup_sel)
            STARTUP_SEL_NO_EXTRA: r = 23'h0;
            STARTUP_SEL_FAST: r = 23'(RESET_FAST_CYC);
            STARTUP_SEL_SLOW: r = 23'(RESET_SLOW_CYC);
            default: r = 23'(RESET_SLOW_CYC);
        endcase
        extra_cycles = r;
    endfunction : extra_cycles

    logic write_divider;
    logic write_trim;
    logic write_async;
    logic unlock_pattern;

    always_comb begin
        write_divider = BUS_REQ.we && (BUS_REQ.addr == CLOCK_DIVIDER_CONTROL_OFS);
        write_trim = BUS_REQ.we && (BUS_REQ.addr == RC_OSCILLATOR_TRIM_OFS);
        write_async = BUS_REQ.we && (BUS_REQ.addr == ASYNC_TIMER_STATUS_REGISTER_OFS);
        unlock_pattern = (BUS_REQ.wdata == UNLOCK_WRITE_VALUE);
    end

    always_comb begin
        s_d = s_q;
        // Fuses are static but come from outside, so they pass two stages
        s_d.fuse_meta = FUSES;
        s_d.fuse_sync = s_q.fuse_meta;

        if (!RST_N) begin
            s_d.divider_change_unlock = 1'b0;
            s_d.unlock_left = 3'h0;
            s_d.divider_select = s_q.fuse_sync.initial_divide_by_eight_fuse ?
                                 SELECT_RESET_PROGRAMMED : SELECT_RESET_UNPROGRAMMED;
            s_d.active_select = s_d.divider_select;
            s_d.div_count = 8'h00;
            s_d.div_phase = 1'b1;
            s_d.div_tick = 1'b0;
            s_d.rc_oscillator_trim = s_q.fuse_sync.factory_trim;
            s_d.async_timer_status_register = ASYNC_RESET;
            s_d.rdata = 8'h00;
            s_d.start_state = ST_RESET_DELAY;
            s_d.start_count = 23'(RESET_BASE_CK) + extra_cycles(s_q.fuse_sync.startup_time_select);
            s_d.core_run = 1'b0;
        end else begin
            // Unlock window counts down from its set cycle and is never renewed
            if (s_q.divider_change_unlock) begin
                if (s_q.unlock_left <= 3'h1) begin
                    s_d.divider_change_unlock = 1'b0;
                    s_d.unlock_left = 3'h0;
                end else begin
                    s_d.unlock_left = s_q.unlock_left - 3'h1;
                end
            end

            if (write_divider) begin
                if (unlock_pattern) begin
                    if (!s_q.divider_change_unlock) begin
                        s_d.divider_change_unlock = 1'b1;
                        s_d.unlock_left = UNLOCK_WINDOW_CYC;
                    end
                    // A repeat inside the window keeps the running count
                end else if (!BUS_REQ.wdata[UNLOCK_BIT] && s_q.divider_change_unlock) begin
                    s_d.divider_select = BUS_REQ.wdata[SELECT_MSB:0];
                    s_d.divider_change_unlock = 1'b0;
                    s_d.unlock_left = 3'h0;
                end
                // Bits six to four are never stored
            end

            if (write_trim) begin
                s_d.rc_oscillator_trim = BUS_REQ.wdata;
            end
            if (write_async) begin
                s_d.async_timer_status_register = 8'h00;
                s_d.async_timer_status_register[EXT_INPUT_ENABLE_POS] =
                    BUS_REQ.wdata[EXT_INPUT_ENABLE_POS];
            end

            // Divider: a new select is adopted only when the old period wraps,
            // so no shortened pulse or faster intermediate rate appears
            s_d.div_tick = 1'b0;
            if (s_q.div_count >= div_limit(s_q.active_select)) begin
                s_d.div_count = 8'h00;
                s_d.active_select = s_q.divider_select;
                s_d.div_tick = 1'b1;
                s_d.div_phase = 1'b1;
            end else begin
                s_d.div_count = s_q.div_count + 8'h01;
                s_d.div_phase = div_high(s_q.active_select, s_d.div_count);
            end

            // Start-up sequencing after reset and after a sleep wake
            case (s_q.start_state)
                ST_RESET_DELAY: begin
                    if (s_q.start_count <= 23'h1) begin
                        s_d.start_state = ST_RUN;
                        s_d.start_count = 23'h0;
                        s_d.core_run = 1'b1;
                    end else begin
                        s_d.start_count = s_q.start_count - 23'h1;
                    end
                end
                ST_RUN: begin
                    if (WAKE_REQ) begin
                        s_d.start_state = ST_WAKE_DELAY;
                        s_d.start_count = 23'(WAKE_CK);
                        s_d.core_run = 1'b0;
                    end
                end
                ST_WAKE_DELAY: begin
                    if (s_q.start_count <= 23'h1) begin
                        s_d.start_state = ST_RUN;
                        s_d.start_count = 23'h0;
                        s_d.core_run = 1'b1;
                    end else begin
                        s_d.start_count = s_q.start_count - 23'h1;
                    end
                end
                default: begin
                    s_d.start_state = ST_RESET_DELAY;
                    s_d.core_run = 1'b0;
                end
            endcase

            // Read data stands in the cycle after the strobe
            s_d.rdata = 8'h00;
            if (BUS_REQ.re) begin
                case (BUS_REQ.addr)
                    CLOCK_DIVIDER_CONTROL_OFS: begin
                        s_d.rdata = {s_q.divider_change_unlock, 3'b000,
                                     s_q.divider_select};
                    end
                    RC_OSCILLATOR_TRIM_OFS: s_d.rdata = s_q.rc_oscillator_trim;
                    ASYNC_TIMER_STATUS_REGISTER_OFS: s_d.rdata = s_q.async_timer_status_register;
                    default: s_d.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        s_q <= s_d;
    end

    always_comb begin
        BUS_RDATA = s_q.rdata;
        // All four domains share one enable so they stay in step
        DOMAIN_EN.io_clock_domain = s_q.div_tick && s_q.core_run;
        DOMAIN_EN.converter_clock_domain = s_q.div_tick && s_q.core_run;
        DOMAIN_EN.core_clock_domain = s_q.div_tick && s_q.core_run;
        DOMAIN_EN.flash_clock_domain = s_q.div_tick && s_q.core_run;
        // During reset the divider is cleared, so the raw clock goes out instead
        CLOCK_OUTPUT_PIN_OE = s_q.fuse_sync.clock_output_fuse;
        CLOCK_OUTPUT_PIN_O = s_q.fuse_sync.clock_output_fuse &&
                             (RST_N ? s_q.div_phase : CLOCK);
        OSC_TRIM = s_q.rc_oscillator_trim;
        TRIM_RANGE_HIGH = s_q.rc_oscillator_trim[TRIM_RANGE_POS];
        TIMER_OSC_EXT_SEL = s_q.async_timer_status_register[EXT_INPUT_ENABLE_POS];
        CORE_RUN = s_q.core_run;
    end

endmodule : scp_prescaler

// *** scp_prescaler_asserts.sv ***
`timescale 1ns/1ps
module scp_prescaler_asserts
    import scp_pkg::*;
#(
    parameter int RESET_FAST_CYC = 20,
    parameter int RESET_SLOW_CYC = 40
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire scp_bus_req_t BUS_REQ,
    input wire logic [7:0] BUS_RDATA,
    input wire scp_fuse_t FUSES,
    input wire logic WAKE_REQ,
    input wire scp_domain_en_t DOMAIN_EN,
    input wire logic CLOCK_OUTPUT_PIN_O,
    input wire logic CLOCK_OUTPUT_PIN_OE,
    input wire logic [7:0] OSC_TRIM,
    input wire logic TRIM_RANGE_HIGH,
    input wire logic TIMER_OSC_EXT_SEL,
    input wire logic CORE_RUN
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic [2:0] win_q;
    logic [3:0] sel_q;
    logic wr_div;
    assign wr_div = BUS_REQ.we && BUS_REQ.addr == CLOCK_DIVIDER_CONTROL_OFS;
    // Shadow of the unlock window and select, kept from bus traffic and the divide-by-eight fuse
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            win_q <= 3'h0;
            sel_q <= FUSES.initial_divide_by_eight_fuse ? SELECT_RESET_PROGRAMMED : 4'h0;
        end else if (wr_div && BUS_REQ.wdata == UNLOCK_WRITE_VALUE && win_q == 3'h0) begin
            win_q <= UNLOCK_WINDOW_CYC;
        end else if (wr_div && !BUS_REQ.wdata[UNLOCK_BIT] && win_q != 3'h0) begin
            win_q <= 3'h0;
            sel_q <= BUS_REQ.wdata[SELECT_MSB:0];
        end else if (win_q != 3'h0) begin
            win_q <= win_q - 3'h1;
        end
    end
    sequence div_read;
        BUS_REQ.re && BUS_REQ.addr == CLOCK_DIVIDER_CONTROL_OFS;
    endsequence
    sequence wake_hold;
        (!CORE_RUN) [*6] ##1 CORE_RUN;
    endsequence
    div_read_a: assert property (div_read |=>
        BUS_RDATA == {($past(win_q) != 3'h0), 3'h0, $past(sel_q)}) else $error("divider readback");
    trim_write_a: assert property (BUS_REQ.we && BUS_REQ.addr == RC_OSCILLATOR_TRIM_OFS |=>
        OSC_TRIM == $past(BUS_REQ.wdata)) else $error("trim write lost");
    trim_range_a: assert property (TRIM_RANGE_HIGH == OSC_TRIM[TRIM_RANGE_POS])
        else $error("range bit mismatch");
    ext_input_a: assert property (BUS_REQ.we && BUS_REQ.addr == ASYNC_TIMER_STATUS_REGISTER_OFS |=>
        TIMER_OSC_EXT_SEL == $past(BUS_REQ.wdata[6])) else $error("external input enable");
    pin_enable_a: assert property (CLOCK_OUTPUT_PIN_OE == FUSES.clock_output_fuse)
        else $error("clock pin enable");
    domains_same_a: assert property (DOMAIN_EN.io_clock_domain == DOMAIN_EN.core_clock_domain &&
        DOMAIN_EN.converter_clock_domain == DOMAIN_EN.flash_clock_domain &&
        DOMAIN_EN.io_clock_domain == DOMAIN_EN.flash_clock_domain) else $error("domains differ");
    div_two_a: assert property (disable iff (!RST_N || WAKE_REQ)
        DOMAIN_EN.core_clock_domain && sel_q == 4'h1 && $past(sel_q, 4) == 4'h1 |=>
        !DOMAIN_EN.core_clock_domain ##1 DOMAIN_EN.core_clock_domain) else $error("divide two");
    wake_delay_a: assert property (CORE_RUN && WAKE_REQ |=> wake_hold)
        else $error("wake delay");
endmodule : scp_prescaler_asserts

bind scp_prescaler scp_prescaler_asserts #(
    .RESET_FAST_CYC(RESET_FAST_CYC), .RESET_SLOW_CYC(RESET_SLOW_CYC)
) u_scp_prescaler_asserts (.CLOCK(CLOCK), .RST_N(RST_N), .BUS_REQ(BUS_REQ),
    .BUS_RDATA(BUS_RDATA), .FUSES(FUSES), .WAKE_REQ(WAKE_REQ), .DOMAIN_EN(DOMAIN_EN),
    .CLOCK_OUTPUT_PIN_O(CLOCK_OUTPUT_PIN_O), .CLOCK_OUTPUT_PIN_OE(CLOCK_OUTPUT_PIN_OE),
    .OSC_TRIM(OSC_TRIM), .TRIM_RANGE_HIGH(TRIM_RANGE_HIGH),
    .TIMER_OSC_EXT_SEL(TIMER_OSC_EXT_SEL), .CORE_RUN(CORE_RUN));

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import scp_pkg::*;
    localparam int FAST = 20;
    localparam logic [7:0] DIV = CLOCK_DIVIDER_CONTROL_OFS;
    localparam logic [7:0] TRM = RC_OSCILLATOR_TRIM_OFS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    scp_bus_req_t bus = '0;
    scp_fuse_t fuses = {1'b1, 1'b1, 2'h1, 8'h5a};
    logic wake = 1'b0;
    logic [7:0] rdata;
    logic [7:0] trim;
    scp_domain_en_t dom;
    logic pin_o, pin_oe, range_high, ext_sel, core_run;
    int num_errors = 0;
    int n_checks = 0;
    int n;
    // Fixed period: the clock never jumps in rate
    always #5 clk = ~clk;
    scp_prescaler #(.RESET_FAST_CYC(FAST), .RESET_SLOW_CYC(40)) u_scp_prescaler (
        .CLOCK(clk), .RST_N(rst_n), .BUS_REQ(bus), .BUS_RDATA(rdata), .FUSES(fuses),
        .WAKE_REQ(wake), .DOMAIN_EN(dom), .CLOCK_OUTPUT_PIN_O(pin_o),
        .CLOCK_OUTPUT_PIN_OE(pin_oe), .OSC_TRIM(trim), .TRIM_RANGE_HIGH(range_high),
        .TIMER_OSC_EXT_SEL(ext_sel), .CORE_RUN(core_run));
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        bus.we <= 1'b0;
        // Let the register update of the write edge settle before any look
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
        bus.re <= 1'b0;
        #1;
        check(16'(rdata), 16'(exp));
    endtask : rd
    // Counts edges until the core runs again; the bound guards a stuck delay
    task automatic wait_run(input int exp);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (core_run !== 1'b1 && n < 500);
        check(16'(n), 16'(exp));
        if (n >= 500)
            print_verdict();
    endtask : wait_run
    // Early pulses may still belong to the old rate, so only the last gap counts
    task automatic period(input int exp);
        int p;
        int t0;
        p = 0;
        t0 = 0;
        n = 0;
        while (p < 4 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
            if (dom.core_clock_domain === 1'b1) begin
                p++;
                if (p == 3)
                    t0 = n;
            end
        end
        check(16'(n - t0), 16'(exp));
        if (n >= 2000)
            print_verdict();
    endtask : period
    initial begin
        repeat (5) @(posedge clk);
        #1;
        check(16'(pin_o), 16'(clk));
        #5;
        check(16'(pin_o), 16'(clk));
        @(posedge clk);
        rst_n <= 1'b1;
        wait_run(14 + FAST);
        check(16'(pin_oe), 16'h1);
        rd(DIV, 8'h03);
        rd(TRM, 8'h5a);
        rd(8'h10, 8'h00);
        wr(TRM, 8'h7f);
        rd(TRM, 8'h7f);
        check(16'(range_high), 16'h0);
        wr(TRM, 8'h80);
        check(16'(range_high), 16'h1);
        check(16'(trim), 16'h80);
        wr(ASYNC_TIMER_STATUS_REGISTER_OFS, 8'hff);
        rd(ASYNC_TIMER_STATUS_REGISTER_OFS, 8'h40);
        check(16'(ext_sel), 16'h1);
        wr(DIV, 8'h81);
        wr(DIV, 8'h05);
        rd(DIV, 8'h03);
        wr(DIV, UNLOCK_WRITE_VALUE);
        rd(DIV, 8'h83);
        repeat (4) @(posedge clk);
        wr(DIV, 8'h05);
        rd(DIV, 8'h03);
        wr(DIV, UNLOCK_WRITE_VALUE);
        wr(DIV, UNLOCK_WRITE_VALUE);
        @(posedge clk);
        wr(DIV, 8'h05);
        rd(DIV, 8'h03);
        wr(DIV, UNLOCK_WRITE_VALUE);
        wr(DIV, 8'h74);
        rd(DIV, 8'h04);
        wr(DIV, UNLOCK_WRITE_VALUE);
        wr(DIV, 8'h0f);
        rd(DIV, 8'h0f);
        period(256);
        for (int s = 0; s <= 8; s++) begin
            wr(DIV, UNLOCK_WRITE_VALUE);
            wr(DIV, 8'(s));
            period(1 << s);
        end
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        wait_run(int'(WAKE_CK));
        fuses <= {1'b0, 1'b0, 2'h1, 8'h5a};
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(DIV, 8'h00);
        check(16'(pin_oe), 16'h0);
        check(16'(pin_o), 16'h0);
        print_verdict();
    end
endmodule : tb_top
